// [pkg/rtc_ctrl_defs.vh]
`ifndef RTC_CTRL_DEFS_VH
`define RTC_CTRL_DEFS_VH

// register indexes on the internal register port
`define ADDR_SECONDS      4'h0
`define ADDR_CTRL_ONE     4'he
`define ADDR_CTRL_TWO     4'hf

// alarm_mode_clock_control field positions
`define C1_WDAY_EN        7
`define C1_DAY_EN         6
`define C1_H24            5
`define C1_CLKDIS_B       4
`define C1_TEST           3
`define C1_CODE_HI        2
`define C1_CODE_LO        0
`define C1_RESET          8'h00

// threshold_and_event_flags field positions
`define C2_THRESH         7
`define C2_VLOW           6
`define C2_XHALT          5
`define C2_PWRON          4
`define C2_CLKDIS_A       3
`define C2_PFLAG          2
`define C2_WFLAG          1
`define C2_DFLAG          0

// periodic codes
`define PC_OFF            3'h0
`define PC_LOW            3'h1
`define PC_2HZ            3'h2
`define PC_1HZ            3'h3
`define PC_SEC            3'h4
`define PC_MIN            3'h5
`define PC_HOUR           3'h6
`define PC_MONTH          3'h7

// oscillator timing, in oscillator cycles except OSC_HZ in Hz and the _US delays in microseconds
`define OSC_HZ            32768
`define SEC_LAST          16'h7fff
`define HALF_SEC          16'h4000
`define QUARTER_SEC       16'h2000
`define TICK_DELAY_US     92
`define TICK_DELAY_CYC    ((`TICK_DELAY_US * `OSC_HZ) / 1000000)
`define ADJ_MAX_US        3784
`define ADJ_MAX_CYC       ((`ADJ_MAX_US * `OSC_HZ) / 1000000)

`endif

// [design/rtc_ctrl.v]
`timescale 1ns/10ps
`include "rtc_ctrl_defs.vh"

// Behaviour
// - control one bits, read/write, clear at power-on
// - each alarm enable gates its alarm interrupt
// - hour format bit: 0 twelve-hour, 1 24-hour
// - twelve-hour reading: bit 20 marks PM
// - clock pin runs unless both disables set
// - codes 000-011: off, low, 2 Hz, 1 Hz
// - level codes 100/101: per second, per minute
// - level codes 110/111: hourly, monthly
// - pulse mode: seconds tick lags falling edge
// - seconds write clears divider, drives pulse-mode output low
// - level mode: tick coincides with falling edge
// - adjustment changes period by up to 3.784 ms
// - control two layout and power-on defaults
// - threshold choice: 1.6 V at 0, 1.3 V at 1
// - periodic flag; level mode write zero releases
// - alarm flags set on match; write zero clears
// - power-on flag holds controls zero, stops interrupt output
module rtc_ctrl (
    input  wire       core_clk,              // 250 MHz core clock
    input  wire       sys_rst,               // power-on reset, synchronous, high
    input  wire [3:0] reg_addr,              // register index
    input  wire       reg_wr,                // write strobe, one cycle
    input  wire [7:0] reg_wdata,             // write data
    output reg  [7:0] reg_rdata,             // read data of reg_addr
    input  wire       osc_clk_in,            // 32.768 kHz oscillator
    input  wire       osc_halt_detect,       // oscillation halt sensed, async
    input  wire       supply_low_detect,     // supply below threshold, async
    input  wire       sec_roll,              // seconds at 59
    input  wire       min_roll,              // minutes at 59
    input  wire       hour_roll,             // hours at 23
    input  wire       month_roll,            // day is last of month
    input  wire       adj_due,               // adjustment applies to next second
    input  wire [7:0] adj_delta,             // signed cycles added to that second
    input  wire       alarm_w_match,         // weekday alarm match pulse
    input  wire       alarm_d_match,         // daily alarm match pulse
    input  wire [4:0] hour_count,            // hour counter, binary 0..23
    output reg  [5:0] hour_reading,          // hour as read by the host
    output reg        sec_tick,              // seconds increment pulse
    output wire       hour_mode_24,          // 24-hour counting
    output wire       weekday_alarm_enable,  // weekday alarm circuit on
    output wire       daily_alarm_enable,    // daily alarm circuit on
    output wire       supply_threshold_choice, // 1 selects lower threshold
    output wire       supply_monitor_enable, // monitor runs while flag clear
    output wire       test_mode,             // factory test bit
    output wire       adj_clear,             // hold adjustment register zero
    output wire       interrupt_out_n_o,     // interrupt pin level when driven
    output reg        interrupt_out_n_oe_n,  // low while pin pulled low
    output wire       clk32_out_o,           // clock pin level when driven
    output reg        clk32_out_oe_n         // low while pin pulled low
);

    reg  [7:0]  ctrl_one_reg;
    reg         thresh_reg, vlow_reg, xhalt_reg, pwron_reg, clkdis_a_reg;
    reg         pflag_reg, wflag_reg, dflag_reg;
    reg  [2:0]  osc_sync_reg;
    reg  [1:0]  halt_sync_reg, vlow_sync_reg;
    reg  [15:0] cnt_reg;
    reg  [15:0] last_reg;
    reg  [15:0] adj_reg;
    wire [2:0]  code;
    wire        level_mode, osc_rise, wrap, wr_one, wr_two, wr_sec, level_hit;
    reg         pulse_low;
    reg  [15:0] adj_next;
    wire [31:0] adj_max_w;
    wire [7:0]  neg_delta;

    // twelve-hour reading: midnight 12, noon 32, PM adds 20
    function [5:0] hour_code;
        input [4:0] h;
        input       h24;
        reg   [4:0] h12;
        reg   [4:0] ones;
        begin
            h12 = 5'd0;
            if (h24) begin
                h12 = h;
            end else if (h == 5'd0 || h == 5'd12) begin
                h12 = 5'd12;
            end else if (h > 5'd12) begin
                h12 = h - 5'd12;
            end else begin
                h12 = h;
            end
            if (h12 >= 5'd20) begin
                ones = h12 - 5'd20;
            end else if (h12 >= 5'd10) begin
                ones = h12 - 5'd10;
            end else begin
                ones = h12;
            end
            hour_code = {h12 >= 5'd20, (h12 >= 5'd10) && (h12 < 5'd20), ones[3:0]};
            if (h >= 5'd12 && !h24) begin
                hour_code[5] = 1'b1;
            end
        end
    endfunction

    assign code       = ctrl_one_reg[`C1_CODE_HI:`C1_CODE_LO];
    assign level_mode = code[2];
    assign wr_one     = reg_wr && (reg_addr == `ADDR_CTRL_ONE);
    assign wr_two     = reg_wr && (reg_addr == `ADDR_CTRL_TWO);
    assign wr_sec     = reg_wr && (reg_addr == `ADDR_SECONDS);

    assign hour_mode_24            = ctrl_one_reg[`C1_H24];
    assign weekday_alarm_enable    = ctrl_one_reg[`C1_WDAY_EN];
    assign daily_alarm_enable      = ctrl_one_reg[`C1_DAY_EN];
    assign test_mode               = ctrl_one_reg[`C1_TEST];
    assign supply_threshold_choice = thresh_reg;
    assign supply_monitor_enable   = ~vlow_reg;
    assign adj_clear               = pwron_reg;
    // 8-bit magnitude keeps the negation in the negative clamp test from widening to 32 bits
    assign adj_max_w               = `ADJ_MAX_CYC;
    assign neg_delta               = 8'h00 - adj_delta;
    assign interrupt_out_n_o       = 1'b0;
    assign clk32_out_o             = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers; oscillator stages 1 and 2 and the last detector stages are looked at
    always @(posedge core_clk) begin
        if (sys_rst) begin
            osc_sync_reg  <= 3'h0;
            halt_sync_reg <= 2'h0;
            vlow_sync_reg <= 2'h0;
        end else begin
            osc_sync_reg  <= {osc_sync_reg[1:0], osc_clk_in};
            halt_sync_reg <= {halt_sync_reg[0], osc_halt_detect};
            vlow_sync_reg <= {vlow_sync_reg[0], supply_low_detect};
        end
    end
    assign osc_rise = osc_sync_reg[1] & ~osc_sync_reg[2];

    ////////////////////////////////////////////////////////////////////////////
    // sub-second divider; count 0 is the falling edge of each second
    assign wrap = osc_rise && (cnt_reg == last_reg);

    // signed adjustment clamped to the longest allowed shift
    always @* begin
        adj_next = {{8{adj_delta[7]}}, adj_delta};
        if (!adj_delta[7] && adj_delta > adj_max_w) begin
            adj_next = adj_max_w[15:0];
        end else if (adj_delta[7] && neg_delta > adj_max_w) begin
            adj_next = 16'h0000 - adj_max_w[15:0];
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst || wr_sec) begin
            cnt_reg  <= 16'h0000;
            last_reg <= `SEC_LAST;
            adj_reg  <= 16'h0000;
        end else if (wrap) begin
            cnt_reg  <= 16'h0000;
            adj_reg  <= adj_due ? adj_next : 16'h0000;
            last_reg <= `SEC_LAST + (adj_due ? adj_next : 16'h0000);
        end else if (osc_rise) begin
            cnt_reg  <= cnt_reg + 16'h0001;
        end
    end

    // pulse-mode waveforms; adjustment stretches or trims the low time
    always @* begin
        case (code)
            `PC_LOW:  pulse_low = 1'b1;
            `PC_2HZ:  pulse_low = (cnt_reg < `QUARTER_SEC + adj_reg) ||
                                  ((cnt_reg >= `HALF_SEC + adj_reg) &&
                                   (cnt_reg < `HALF_SEC + `QUARTER_SEC + adj_reg));
            `PC_1HZ:  pulse_low = cnt_reg < `HALF_SEC + adj_reg;
            default:  pulse_low = 1'b0;
        endcase
    end

    // seconds tick: late in pulse mode, on the falling edge otherwise
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sec_tick <= 1'b0;
        end else if (code == `PC_2HZ || code == `PC_1HZ) begin
            sec_tick <= osc_rise && (cnt_reg == `TICK_DELAY_CYC - 1);
        end else begin
            sec_tick <= wrap;
        end
    end

    // level-mode events gated by the counter roll-overs
    assign level_hit = wrap && (code == `PC_SEC ||
                       (code == `PC_MIN && sec_roll) ||
                       (code == `PC_HOUR && sec_roll && min_roll) ||
                       (code == `PC_MONTH && sec_roll && min_roll &&
                        hour_roll && month_roll));

    ////////////////////////////////////////////////////////////////////////////
    // control registers; power-on flag pins all but xhalt_reg at zero
    always @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl_one_reg <= `C1_RESET;
            thresh_reg   <= 1'b0;
            vlow_reg     <= 1'b0;
            xhalt_reg    <= 1'b0;
            pwron_reg    <= 1'b1;
            clkdis_a_reg <= 1'b0;
        end else if (pwron_reg) begin
            ctrl_one_reg <= `C1_RESET;
            thresh_reg   <= 1'b0;
            vlow_reg     <= 1'b0;
            clkdis_a_reg <= 1'b0;
            xhalt_reg    <= halt_sync_reg[1] ? 1'b0 :
                            (wr_two ? reg_wdata[`C2_XHALT] : xhalt_reg);
            pwron_reg    <= ~(wr_two && !reg_wdata[`C2_PWRON]);
        end else begin
            if (wr_one) begin
                ctrl_one_reg <= reg_wdata;
            end
            if (wr_two) begin
                thresh_reg   <= reg_wdata[`C2_THRESH];
                clkdis_a_reg <= reg_wdata[`C2_CLKDIS_A];
            end
            // a set in the same cycle as a clearing write wins
            vlow_reg  <= vlow_sync_reg[1] | (vlow_reg & ~(wr_two & ~reg_wdata[`C2_VLOW]));
            xhalt_reg <= halt_sync_reg[1] ? 1'b0 :
                         (wr_two ? reg_wdata[`C2_XHALT] : xhalt_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event flags; set beats a simultaneous write of zero
    always @(posedge core_clk) begin
        if (sys_rst || pwron_reg) begin
            pflag_reg <= 1'b0;
            wflag_reg <= 1'b0;
            dflag_reg <= 1'b0;
        end else begin
            if (level_mode) begin
                pflag_reg <= level_hit | (pflag_reg & ~wr_one &
                             ~(wr_two & ~reg_wdata[`C2_PFLAG]));
            end else begin
                pflag_reg <= pulse_low;
            end
            wflag_reg <= ctrl_one_reg[`C1_WDAY_EN] & (alarm_w_match |
                         (wflag_reg & ~(wr_two & ~reg_wdata[`C2_WFLAG])));
            dflag_reg <= ctrl_one_reg[`C1_DAY_EN] & (alarm_d_match |
                         (dflag_reg & ~(wr_two & ~reg_wdata[`C2_DFLAG])));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and read-back; clock pin is the resampled oscillator, so it
    // carries up to one core period of jitter
    always @(posedge core_clk) begin
        if (sys_rst) begin
            interrupt_out_n_oe_n <= 1'b1;
            clk32_out_oe_n       <= 1'b1;
            reg_rdata            <= 8'h00;
            hour_reading         <= 6'h00;
        end else begin
            interrupt_out_n_oe_n <= pwron_reg | ~(pflag_reg | wflag_reg | dflag_reg);
            clk32_out_oe_n       <= (ctrl_one_reg[`C1_CLKDIS_B] & clkdis_a_reg) |
                                    osc_sync_reg[1];
            hour_reading         <= hour_code(hour_count, ctrl_one_reg[`C1_H24]);
            // alarm flags are gated on read so they show 0 as soon as the enable drops
            case (reg_addr)
                `ADDR_CTRL_ONE: reg_rdata <= ctrl_one_reg;
                `ADDR_CTRL_TWO: reg_rdata <= {thresh_reg, vlow_reg, xhalt_reg, pwron_reg,
                                              clkdis_a_reg, pflag_reg,
                                              wflag_reg & ctrl_one_reg[`C1_WDAY_EN],
                                              dflag_reg & ctrl_one_reg[`C1_DAY_EN]};
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// [testbench/rtc_ctrl_assertions.sv]
`timescale 1ns/10ps
module rtc_ctrl_assertions (
    input wire       core_clk,                // core clock
    input wire       sys_rst,                 // sync reset
    input wire [3:0] reg_addr,                // register index
    input wire       reg_wr,                  // write strobe
    input wire [7:0] reg_wdata,               // write data
    input wire [7:0] reg_rdata,               // read data
    input wire       alarm_w_match,           // weekday match
    input wire       hour_mode_24,            // hour format
    input wire       weekday_alarm_enable,    // weekday enable
    input wire       daily_alarm_enable,      // daily enable
    input wire       supply_threshold_choice, // threshold bit
    input wire       test_mode,               // test bit
    input wire       adj_clear,               // power-on flag view
    input wire       interrupt_out_n_oe_n,    // interrupt pin enable
    input wire       clk32_out_oe_n           // clock pin enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // reset must not leave either open-drain pin pulled
    reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
        reg_rdata == 8'h00 && interrupt_out_n_oe_n && clk32_out_oe_n) else $error("reset state");
    ctrl_write_a: assert property (reg_wr && reg_addr == 4'he && !adj_clear |=>
        {weekday_alarm_enable, daily_alarm_enable, hour_mode_24, 1'b0, test_mode, 3'h0}
        == ($past(reg_wdata) & 8'he8)) else $error("ctrl one write");
    readback_a: assert property ($past(reg_addr) == 4'he |-> reg_rdata[7:5] ==
        {$past(weekday_alarm_enable), $past(daily_alarm_enable), $past(hour_mode_24)})
        else $error("ctrl one readback");
    poweron_hold_a: assert property (adj_clear |-> !hour_mode_24 && !test_mode &&
        !weekday_alarm_enable && !daily_alarm_enable && !supply_threshold_choice)
        else $error("controls not held");
    int_release_a: assert property (adj_clear |-> interrupt_out_n_oe_n)
        else $error("interrupt pulled in power-on");
    threshold_write_a: assert property (reg_wr && reg_addr == 4'hf && !adj_clear |=>
        {supply_threshold_choice, 7'h0} == ($past(reg_wdata) & 8'h80)) else $error("threshold");
    alarm_gate_a: assert property ($past(reg_addr) == 4'hf &&
        !$past(weekday_alarm_enable) |-> !reg_rdata[1]) else $error("alarm flag ungated");
    alarm_int_a: assert property (weekday_alarm_enable && alarm_w_match && !adj_clear
        |-> ##[1:3] !interrupt_out_n_oe_n) else $error("alarm not signalled");
    flag_keep_a: assert property (adj_clear && !(reg_wr && reg_addr == 4'hf &&
        !reg_wdata[4]) |=> adj_clear) else $error("power-on flag lost");
    flag_clear_a: assert property (adj_clear && reg_wr && reg_addr == 4'hf &&
        !reg_wdata[4] |=> !adj_clear) else $error("power-on flag stuck");
endmodule

// [testbench/host_model.sv]
`timescale 1ns/10ps
// host side of the register port, changes only on falling edges
module host_model (
    input  wire       core_clk,  // core clock
    input  wire [7:0] reg_rdata, // read data
    output reg  [3:0] reg_addr,  // register index
    output reg        reg_wr,    // write strobe
    output reg  [7:0] reg_wdata  // write data
);
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // one-cycle write; data goes stale once the strobe drops
    task wr(input [3:0] a, input [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = (a == 4'he) ? (d & 8'hf7) : d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask
    // answer is registered, so it is taken one edge after the index
    task rd(input [3:0] a, output [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule

// [testbench/rtc_ctrl_bench.sv]
`timescale 1ns/10ps
module rtc_ctrl_bench;
    reg        core_clk, sys_rst, osc_clk_in, osc_halt_detect, supply_low_detect;
    reg        alarm_w_match, alarm_d_match, rolls;
    reg  [4:0] hour_count;
    reg  [7:0] rv;
    wire [3:0] reg_addr;
    wire       reg_wr;
    wire [7:0] reg_wdata, reg_rdata;
    wire [5:0] hour_reading;
    wire       sec_tick, hour_mode_24, weekday_alarm_enable, daily_alarm_enable;
    wire       supply_threshold_choice, supply_monitor_enable, test_mode, adj_clear;
    wire       int_o, interrupt_out_n_oe_n, clk_o, clk32_out_oe_n;
    int        num_errors = 0;
    int        n_checks = 0;
    // both pins are open drain with pull-ups
    wire int_pin = interrupt_out_n_oe_n ? 1'b1 : int_o;
    wire clk_pin = clk32_out_oe_n ? 1'b1 : clk_o;
    rtc_ctrl rtc_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .osc_clk_in(osc_clk_in), .osc_halt_detect(osc_halt_detect),
        .supply_low_detect(supply_low_detect), .sec_roll(rolls), .min_roll(rolls),
        .hour_roll(rolls), .month_roll(rolls), .adj_due(rolls), .adj_delta(8'h00),
        .alarm_w_match(alarm_w_match), .alarm_d_match(alarm_d_match),
        .hour_count(hour_count), .hour_reading(hour_reading), .sec_tick(sec_tick),
        .hour_mode_24(hour_mode_24), .weekday_alarm_enable(weekday_alarm_enable),
        .daily_alarm_enable(daily_alarm_enable), .test_mode(test_mode),
        .supply_threshold_choice(supply_threshold_choice), .adj_clear(adj_clear),
        .supply_monitor_enable(supply_monitor_enable), .interrupt_out_n_o(int_o),
        .interrupt_out_n_oe_n(interrupt_out_n_oe_n), .clk32_out_o(clk_o),
        .clk32_out_oe_n(clk32_out_oe_n));
    host_model host_model_inst (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string what, input [7:0] seen, input [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task rdchk(input [3:0] a, input [7:0] exp);
        host_model_inst.rd(a, rv);
        chk("register", rv, exp);
    endtask
    task wr(input [3:0] a, input [7:0] d);
        host_model_inst.wr(a, d);
    endtask
    // expected host hour reading; pm marked by the bit worth 20
    function [5:0] hexp(input [4:0] h, input m);
        reg [4:0] x;
        begin
            x = (m || (h != 5'd0 && h <= 5'd12)) ? h : ((h == 5'd0) ? 5'd12 : h - 5'd12);
            hexp = 6'((x / 10) * 16 + x % 10) | ((!m && h >= 5'd12) ? 6'h20 : 6'h00);
        end
    endfunction
    // short windows only: a whole second would cost far too many core cycles
    task clk_runs(input [7:0] exp);
        int n;
        reg last;
        n = 0;
        last = clk_pin;
        repeat (80) begin
            @(negedge core_clk);
            if (clk_pin !== last) n++;
            last = clk_pin;
        end
        chk("clock pin", {7'h0, n > 0}, exp);
    endtask
    task do_reset;
        sys_rst = 1'b1;
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
    endtask
    task final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_power;
        rdchk(4'hf, 8'h10);
        wr(4'he, 8'hf7);
        rdchk(4'he, 8'h00);
        chk("interrupt pin", {7'h0, int_pin}, 8'h01);
        clk_runs(8'h01);
        wr(4'hf, 8'h00);
        rdchk(4'hf, 8'h00);
    endtask
    task t_ctrl;
        wr(4'he, 8'hf0);
        rdchk(4'he, 8'hf0);
        chk("enables", {5'h0, weekday_alarm_enable, daily_alarm_enable, hour_mode_24}, 8'h07);
        clk_runs(8'h01);
        wr(4'hf, 8'h08);
        rdchk(4'hf, 8'h08);
        clk_runs(8'h00);
        chk("clock idle", {7'h0, clk_pin}, 8'h01);
        wr(4'he, 8'h00);
        clk_runs(8'h01);
        wr(4'hf, 8'h00);
    endtask
    task t_hours;
        for (int m = 0; m < 2; m++) begin
            wr(4'he, m ? 8'h20 : 8'h00);
            for (int h = 0; h < 24; h++) begin
                hour_count = 5'(h);
                repeat (3) @(negedge core_clk);
                chk("hour", {2'b00, hour_reading}, {2'b00, hexp(5'(h), m[0])});
            end
        end
    endtask
    task t_periodic;
        int n;
        wr(4'he, 8'h01);
        repeat (4) @(negedge core_clk);
        chk("fixed low", {7'h0, int_pin}, 8'h00);
        rdchk(4'hf, 8'h04);
        wr(4'he, 8'h00);
        wr(4'hf, 8'h00);
        repeat (4) @(negedge core_clk);
        chk("off", {7'h0, int_pin}, 8'h01);
        // seconds writes are not gated by the hour format, which is zero here
        for (int c = 2; c < 4; c++) begin
            wr(4'he, 8'(c));
            wr(4'h0, 8'h00);
            // the divider restarts, so exactly one tick follows a few oscillator cycles later
            n = 0;
            repeat (40) begin
                @(negedge core_clk);
                if (sec_tick === 1'b1) n++;
            end
            chk("seconds tick", 8'(n), 8'h01);
            chk("pulse low", {7'h0, int_pin}, 8'h00);
            rdchk(4'hf, 8'h04);
        end
        // after a level code write and a flag clear, neither the flag nor the pin shows an event
        for (int c = 4; c < 8; c++) begin
            wr(4'he, 8'(c));
            wr(4'hf, 8'h00);
            rdchk(4'hf, 8'h00);
            chk("level idle", {7'h0, int_pin}, 8'h01);
        end
    endtask
    task t_alarm;
        wr(4'he, 8'h80);
        @(negedge core_clk);
        alarm_w_match = 1'b1;
        alarm_d_match = 1'b1;
        @(negedge core_clk);
        alarm_w_match = 1'b0;
        alarm_d_match = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("alarm pin", {7'h0, int_pin}, 8'h00);
        rdchk(4'hf, 8'h02);
        wr(4'hf, 8'h03);
        rdchk(4'hf, 8'h02);
        wr(4'hf, 8'h00);
        rdchk(4'hf, 8'h00);
        chk("alarm release", {7'h0, int_pin}, 8'h01);
    endtask
    task t_supply;
        wr(4'hf, 8'h80);
        chk("threshold", {7'h0, supply_threshold_choice}, 8'h01);
        supply_low_detect = 1'b1;
        repeat (8) @(negedge core_clk);
        supply_low_detect = 1'b0;
        rdchk(4'hf, 8'hc0);
        chk("monitor", {7'h0, supply_monitor_enable}, 8'h00);
        wr(4'hf, 8'h80);
        rdchk(4'hf, 8'h80);
        wr(4'he, 8'hf0);
        do_reset;
        rdchk(4'he, 8'h00);
        rdchk(4'hf, 8'h10);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // oscillator edges fall midway between core clock edges, one period per eight core periods
    initial begin
        osc_clk_in = 1'b0;
        #3;
        forever #16 osc_clk_in = ~osc_clk_in;
    end
    initial begin
        #200000;
        num_errors++;
        final_report;
    end
    initial begin
        {sys_rst, osc_halt_detect, supply_low_detect, alarm_w_match, alarm_d_match} = 5'h10;
        rolls = 1'b0;
        hour_count = 5'h00;
        do_reset;
        t_power;
        t_ctrl;
        t_hours;
        t_periodic;
        t_alarm;
        t_supply;
        final_report;
    end
endmodule
bind rtc_ctrl rtc_ctrl_assertions rtc_ctrl_assertions_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .alarm_w_match(alarm_w_match), .hour_mode_24(hour_mode_24),
    .weekday_alarm_enable(weekday_alarm_enable), .daily_alarm_enable(daily_alarm_enable),
    .supply_threshold_choice(supply_threshold_choice), .test_mode(test_mode),
    .adj_clear(adj_clear), .interrupt_out_n_oe_n(interrupt_out_n_oe_n),
    .clk32_out_oe_n(clk32_out_oe_n));
